// ---- hw/psp_device.sv ----
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module psp_device (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  psp_if.device psp,
  input wire logic [2:0] I_PORT_E_PINS,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [11:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [2:0] O_PORT_E_OE,
  output logic O_IRQ
);
  logic [1:0] phase;
  logic [7:0] out_latch;
  logic [7:0] in_latch;
  logic input_buffer_full, output_buffer_full, ovf, mode, irq_flag, irq_en;
  logic [2:0] dir;
  logic [2:0] acfg;
  logic wr_act, rd_act, wr_done, rd_done, wr_q2, rd_q2;
  logic [31:0] rdata;
  logic aw_hold, w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  // host access decode
  wire sel_wr = mode && !psp.cs_n && !psp.wr_n;
  wire sel_rd = mode && !psp.cs_n && !psp.rd_n;
  wire at_q2 = (phase == psp_pkg::PHASE_Q2);
  wire at_q4 = (phase == psp_pkg::PHASE_Q4);
  wire wr_end = wr_q2 && at_q4;
  wire rd_end = rd_q2 && at_q4;
  // axi write: register write applies once, when both halves are held
  wire do_wr = aw_hold && w_hold && !O_BVALID;
  wire aw_take = I_AWVALID && O_AWREADY;
  wire w_take = I_WVALID && O_WREADY;
  wire [11:0] wa = aw_addr;
  wire [7:0] wd = w_data[7:0];
  wire wl0 = w_lane0;
  wire cpu_wr_data = do_wr && wl0 && wa == psp_pkg::ADDR_DATA_LATCH;
  wire cpu_wr_dir = do_wr && wl0 && wa == psp_pkg::ADDR_PORT_E_DIR_STATUS;
  wire cpu_wr_acfg = do_wr && wl0 && wa == psp_pkg::ADDR_ANALOG_PIN_CONFIG;
  wire cpu_wr_flag = do_wr && wl0 && wa == psp_pkg::ADDR_IRQ_FLAGS;
  wire cpu_wr_en = do_wr && wl0 && wa == psp_pkg::ADDR_IRQ_ENABLES;
  wire wr_known = wa == psp_pkg::ADDR_DATA_LATCH || wa == psp_pkg::ADDR_PORT_E_DIR_STATUS
    || wa == psp_pkg::ADDR_ANALOG_PIN_CONFIG || wa == psp_pkg::ADDR_IRQ_FLAGS
    || wa == psp_pkg::ADDR_IRQ_ENABLES || wa == psp_pkg::ADDR_PORT_E_PIN_DATA;
  wire do_rd = I_ARVALID && !O_RVALID;
  wire cpu_rd_data = do_rd && O_ARREADY && I_ARADDR == psp_pkg::ADDR_DATA_LATCH;
  // pins set to analog read as zero; digital only with full config
  wire [2:0] pin_rd = (acfg == psp_pkg::ANALOG_CFG_DIGITAL) ? I_PORT_E_PINS : 3'h0;
  wire [7:0] dir_status = {input_buffer_full, output_buffer_full, ovf, mode, 1'b0, dir};
  // read mux
  always_comb
  begin
    rdata = 32'h00000000;
    case (I_ARADDR)
      psp_pkg::ADDR_DATA_LATCH: rdata[7:0] = in_latch;
      psp_pkg::ADDR_PORT_E_DIR_STATUS: rdata[7:0] = dir_status;
      psp_pkg::ADDR_ANALOG_PIN_CONFIG: rdata[2:0] = acfg;
      psp_pkg::ADDR_IRQ_FLAGS: rdata[psp_pkg::BIT_IRQ] = irq_flag;
      psp_pkg::ADDR_IRQ_ENABLES: rdata[psp_pkg::BIT_IRQ] = irq_en;
      psp_pkg::ADDR_PORT_E_PIN_DATA: rdata[2:0] = pin_rd;
      default: rdata = 32'h00000000;
    endcase
  end
  // four phase counter
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
    if (I_RST) phase <= 2'h0;
    else phase <= phase + 2'h1;
  // host strobes and latches, async to the cpu view
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      wr_act <= 1'b0;
      rd_act <= 1'b0;
      wr_done <= 1'b0;
      rd_done <= 1'b0;
      wr_q2 <= 1'b0;
      rd_q2 <= 1'b0;
      in_latch <= 8'h00;
    end
    else
    begin
      wr_act <= sel_wr;
      rd_act <= sel_rd;
      if (sel_wr) in_latch <= psp.bus_data;
      // completion waits for the next Q2, then is marked at Q4
      if (wr_act && !sel_wr) wr_done <= 1'b1;
      else if (wr_end) wr_done <= 1'b0;
      if (rd_act && !sel_rd) rd_done <= 1'b1;
      else if (rd_end) rd_done <= 1'b0;
      // a Q2 must pass after the release before the ending Q4
      if (wr_end) wr_q2 <= 1'b0;
      else if (wr_done && at_q2) wr_q2 <= 1'b1;
      if (rd_end) rd_q2 <= 1'b0;
      else if (rd_done && at_q2) rd_q2 <= 1'b1;
    end
  end
  // status, control and irq registers
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      mode <= 1'b0;
      dir <= psp_pkg::DIR_STATUS_RESET[2:0];
      input_buffer_full <= 1'b0;
      output_buffer_full <= 1'b0;
      ovf <= 1'b0;
      acfg <= psp_pkg::ANALOG_CFG_RESET;
      irq_flag <= 1'b0;
      irq_en <= 1'b0;
      out_latch <= 8'h00;
    end
    else
    begin
      if (cpu_wr_dir)
      begin
        mode <= wd[psp_pkg::BIT_MODE];
        dir <= wd[2:0];
      end
      if (cpu_wr_acfg) acfg <= wd[2:0];
      if (cpu_wr_data) out_latch <= wd;
      if (cpu_wr_en) irq_en <= wd[psp_pkg::BIT_IRQ];
      // input full: set on write end, cleared by cpu read, held 0 off mode
      if (!mode) input_buffer_full <= 1'b0;
      else if (wr_end) input_buffer_full <= 1'b1;
      else if (cpu_rd_data) input_buffer_full <= 1'b0;
      // output full
      if (!mode) output_buffer_full <= 1'b0;
      else if (sel_rd && !rd_act) output_buffer_full <= 1'b0;
      else if (cpu_wr_data) output_buffer_full <= 1'b1;
      // overflow: second write start while unread; set wins over clear
      if (sel_wr && !wr_act && input_buffer_full && !cpu_rd_data) ovf <= 1'b1;
      else if (cpu_wr_dir) ovf <= wd[psp_pkg::BIT_OVF];
      // irq flag sticky; set wins over firmware clear
      if (wr_end || rd_end) irq_flag <= 1'b1;
      else if (cpu_wr_flag) irq_flag <= wd[psp_pkg::BIT_IRQ];
    end
  end
  // axi4-lite slave
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= psp_pkg::AXI_OKAY;
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= psp_pkg::AXI_OKAY;
    end
    else
    begin
      // write ready does not wait for valid, but drops while an address or data beat is held or a response is pending
      O_AWREADY <= !aw_hold && !aw_take && !O_BVALID;
      O_WREADY <= !w_hold && !w_take && !O_BVALID;
      if (I_AWVALID && O_AWREADY)
      begin
        aw_hold <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_hold <= 1'b1;
        w_data <= I_WDATA;
        w_lane0 <= I_WSTRB[0];
      end
      if (do_wr && aw_hold && w_hold)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_known ? psp_pkg::AXI_OKAY : psp_pkg::AXI_DECERR;
        O_AWREADY <= 1'b0;
        O_WREADY <= 1'b0;
      end
      else if (O_BVALID && I_BREADY) O_BVALID <= 1'b0;
      O_ARREADY <= do_rd && !O_ARREADY;
      if (do_rd && O_ARREADY)
      begin
        O_RVALID <= 1'b1;
        O_RDATA <= rdata;
        O_RRESP <= (rdata == 32'h00000000 && !(I_ARADDR inside {psp_pkg::ADDR_DATA_LATCH,
          psp_pkg::ADDR_PORT_E_DIR_STATUS, psp_pkg::ADDR_ANALOG_PIN_CONFIG, psp_pkg::ADDR_IRQ_FLAGS,
          psp_pkg::ADDR_IRQ_ENABLES, psp_pkg::ADDR_PORT_E_PIN_DATA})) ? psp_pkg::AXI_DECERR : psp_pkg::AXI_OKAY;
      end
      else if (O_RVALID && I_RREADY) O_RVALID <= 1'b0;
    end
  end
  // pin drivers: data bus drive follows only the host read strobe in mode
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      psp.dev_data <= 8'h00;
      psp.dev_data_oe <= 1'b0;
      O_PORT_E_OE <= 3'h0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      psp.dev_data <= out_latch;
      psp.dev_data_oe <= sel_rd;
      O_PORT_E_OE <= ~dir;
      O_IRQ <= irq_flag && irq_en;
    end
  end
endmodule
`default_nettype wire

// ---- hw/psp_pkg.sv ----
package psp_pkg;
  // register offsets as word indices; times four gives the byte address on the AXI4-Lite side
  localparam logic [7:0] OFS_PORT_E_PIN_DATA = 8'h09;
  localparam logic [7:0] OFS_PORT_E_DIR_STATUS = 8'h89;
  localparam logic [7:0] OFS_ANALOG_PIN_CONFIG = 8'h9F;
  // own registers of the device end: the data latch and irq flag/enable
  localparam logic [11:0] ADDR_DATA_LATCH = 12'h020;
  localparam logic [11:0] ADDR_PORT_E_DIR_STATUS = 12'h224;
  localparam logic [11:0] ADDR_ANALOG_PIN_CONFIG = 12'h27C;
  localparam logic [11:0] ADDR_IRQ_FLAGS = 12'h030;
  localparam logic [11:0] ADDR_IRQ_ENABLES = 12'h230;
  localparam logic [11:0] ADDR_PORT_E_PIN_DATA = 12'h024;
  // own registers of the host end
  localparam logic [11:0] ADDR_HOST_CMD = 12'h000;
  localparam logic [11:0] ADDR_HOST_STATUS = 12'h004;
  // field positions in the direction and status register; BIT_IRQ is the bit in the irq flag and enable registers
  localparam int BIT_IN_FULL = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_OVF = 5;
  localparam int BIT_MODE = 4;
  localparam int BIT_IRQ = 7;
  localparam logic [7:0] DIR_STATUS_RESET = 8'h07;
  localparam logic [2:0] ANALOG_CFG_RESET = 3'h0;
  localparam logic [2:0] ANALOG_CFG_DIGITAL = 3'h7;
  // four-phase instruction clock, one phase per system clock
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  // host strobe count; strobe low time is one cycle more than this
  localparam logic [3:0] HOST_STROBE_CYCLES = 4'h6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
endpackage

// ---- hw/psp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface psp_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  // resolved bus level seen by both ends
  wire [7:0] bus_data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'h00);
  modport device (input cs_n, input rd_n, input wr_n, input bus_data, output dev_data, output dev_data_oe);
  modport host (output cs_n, output rd_n, output wr_n, output host_data, output host_data_oe, input bus_data);
endinterface
`default_nettype wire

// ---- hw/psp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module psp_host (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  psp_if.host psp,
  input wire logic I_START,
  input wire logic I_WRITE,
  input wire logic [7:0] I_DATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic [7:0] O_DATA
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_GAP = 2'b10
  } psp_host_state_type;
  psp_host_state_type state;
  logic [3:0] cnt;
  logic is_wr;
  // strobe sequencer: select plus strobe low, then release
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      is_wr <= 1'b0;
      psp.cs_n <= 1'b1;
      psp.rd_n <= 1'b1;
      psp.wr_n <= 1'b1;
      psp.host_data <= 8'h00;
      psp.host_data_oe <= 1'b0;
      O_BUSY <= 1'b0;
      O_DONE <= 1'b0;
      O_DATA <= 8'h00;
    end
    else
    begin
      O_DONE <= 1'b0;
      case (state)
        ST_IDLE:
          if (I_START)
          begin
            state <= ST_LOW;
            is_wr <= I_WRITE;
            cnt <= psp_pkg::HOST_STROBE_CYCLES;
            psp.cs_n <= 1'b0;
            psp.wr_n <= !I_WRITE;
            psp.rd_n <= I_WRITE;
            psp.host_data <= I_DATA;
            psp.host_data_oe <= I_WRITE;
            O_BUSY <= 1'b1;
          end
        ST_LOW:
          if (cnt == 4'h0)
          begin
            if (!is_wr) O_DATA <= psp.bus_data;
            psp.cs_n <= 1'b1;
            psp.rd_n <= 1'b1;
            psp.wr_n <= 1'b1;
            psp.host_data_oe <= 1'b0;
            cnt <= psp_pkg::HOST_STROBE_CYCLES;
            state <= ST_GAP;
          end
          else cnt <= cnt - 4'h1;
        ST_GAP:
          if (cnt == 4'h0)
          begin
            state <= ST_IDLE;
            O_BUSY <= 1'b0;
            O_DONE <= 1'b1;
          end
          else cnt <= cnt - 4'h1;
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- bench/psp_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module psp_monitor (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic [7:0] bus_data
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  // selected strobes
  wire rd_on = !cs_n && !rd_n;
  wire wr_on = !cs_n && !wr_n;
  // data bus ownership and hold
  a_no_fight: assert property (!(dev_data_oe && host_data_oe)) else $error("bus fight");
  a_drive_cause: assert property (dev_data_oe |-> $past(rd_on) || $past(rd_on, 2))
    else $error("stray drive");
  a_read_drive: assert property (rd_on [*3] |-> dev_data_oe && bus_data == dev_data)
    else $error("no read drive");
  a_read_hold: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data))
    else $error("read data moved");
  a_write_hold: assert property (wr_on && $past(wr_on) |-> host_data_oe && $stable(host_data))
    else $error("write data moved");
  // host strobe framing
  a_strobe_len: assert property ($fell(cs_n) |-> !cs_n [*7] ##1 cs_n) else $error("select width");
  a_strobe_gap: assert property ($rose(cs_n) |-> cs_n [*7]) else $error("select gap");
  a_one_strobe: assert property (rd_n || wr_n) else $error("two strobes");
  // main transfers
  c_write: cover property (wr_on [*3]);
  c_read: cover property (rd_on ##1 dev_data_oe);
  c_gap: cover property ($rose(cs_n));
endmodule
`default_nettype wire

// ---- bench/parallel_slave_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module parallel_slave_port_test;
  localparam logic [11:0] a_st = psp_pkg::ADDR_PORT_E_DIR_STATUS;
  localparam logic [11:0] a_fl = psp_pkg::ADDR_IRQ_FLAGS;
  localparam logic [11:0] a_lat = psp_pkg::ADDR_DATA_LATCH;
  localparam logic [11:0] a_cf = psp_pkg::ADDR_ANALOG_PIN_CONFIG;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] aw = 12'h0;
  logic [11:0] ar = 12'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, st = 1'h0, hw = 1'h0;
  logic [2:0] pins = 3'h0;
  logic [7:0] hd = 8'h0;
  wire awr, wr, bv, arr, rv, irq, done, busy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] oe;
  wire [7:0] hq;
  // model state
  logic [31:0] v, rsp;
  logic [7:0] olat, ilat, q;
  logic input_buffer_full = 1'h0, output_buffer_full = 1'h0, ovf = 1'h0, mode = 1'h0, flag = 1'h0, en = 1'h0;
  int num_errors = 0, n_tests = 0, seed = 92;
  psp_if pif ();
  psp_device psp_device_i (.I_CLK_SYS(clk), .I_RST(rst), .psp(pif), .I_PORT_E_PINS(pins), .I_AWADDR(aw),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr),
    .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ar), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr), .O_PORT_E_OE(oe), .O_IRQ(irq));
  psp_host psp_host_i (.I_CLK_SYS(clk), .I_RST(rst), .psp(pif), .I_START(st), .I_WRITE(hw), .I_DATA(hd),
    .O_BUSY(busy), .O_DONE(done), .O_DATA(hq));
  psp_monitor psp_monitor_i (.I_CLK_SYS(clk), .I_RST(rst), .cs_n(pif.cs_n), .rd_n(pif.rd_n),
    .wr_n(pif.wr_n), .host_data(pif.host_data), .host_data_oe(pif.host_data_oe),
    .dev_data(pif.dev_data), .dev_data_oe(pif.dev_data_oe), .bus_data(pif.bus_data));
  // clock
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bus master cycles
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end
    while (awv || wv);
    br <= 1'h1;
    do @(posedge clk); while (!bv);
    rsp = {30'h0, bresp};
    br <= 1'h0;
  endtask
  task automatic axr(input logic [11:0] a);
    ar <= a;
    arv <= 1'h1;
    do @(posedge clk); while (!arr);
    arv <= 1'h0;
    rr <= 1'h1;
    do @(posedge clk); while (!rv);
    v = rdata;
    rsp = {30'h0, rresp};
    rr <= 1'h0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    axr(a);
    chk(v, e);
  endtask
  function automatic logic [31:0] sx();
    return {24'h0, input_buffer_full, output_buffer_full, ovf, mode, 4'h7};
  endfunction
  task automatic fchk();
    rchk(a_fl, {24'h0, flag, 7'h0});
    chk({31'h0, irq}, {31'h0, flag & en});
  endtask
  // host and cpu data transfers with model update
  task automatic hop(input logic w, input logic [7:0] d);
    hw <= w;
    hd <= d;
    st <= 1'h1;
    @(posedge clk);
    st <= 1'h0;
    @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    do @(posedge clk); while (!done);
    chk({31'h0, busy}, 32'h0);
    @(posedge clk);
    q = hq;
  endtask
  task automatic hwr(input logic [7:0] d);
    hop(1'h1, d);
    ovf = ovf | input_buffer_full;
    input_buffer_full = 1'h1;
    flag = 1'h1;
    ilat = d;
    rchk(a_st, sx());
    fchk();
  endtask
  task automatic hrd();
    hop(1'h0, 8'h0);
    chk({24'h0, q}, {24'h0, olat});
    output_buffer_full = 1'h0;
    flag = 1'h1;
    rchk(a_st, sx());
    fchk();
  endtask
  task automatic cwr(input logic [7:0] d);
    axw(a_lat, {24'h0, d});
    olat = d;
    output_buffer_full = mode;
    rchk(a_st, sx());
  endtask
  task automatic crd();
    axr(a_lat);
    chk(v, {24'h0, ilat});
    input_buffer_full = 1'h0;
    rchk(a_st, sx());
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    pins <= 3'($random(seed));
    @(posedge clk);
    chk({29'h0, oe}, 32'h0);
    rchk(a_st, 32'h7);
    rchk(a_cf, 32'h0);
    rchk(psp_pkg::ADDR_PORT_E_PIN_DATA, 32'h0);
    axr(12'hFFC);
    chk(rsp, {30'h0, psp_pkg::AXI_DECERR});
    axw(12'hFFC, 32'h0);
    chk(rsp, {30'h0, psp_pkg::AXI_DECERR});
    axw(a_cf, 32'h7);
    chk(rsp, {30'h0, psp_pkg::AXI_OKAY});
    rchk(psp_pkg::ADDR_PORT_E_PIN_DATA, {29'h0, pins});
    cwr(8'h5A);
    mode = 1'h1;
    axw(a_st, sx());
    axw(psp_pkg::ADDR_IRQ_ENABLES, 32'h80);
    en = 1'h1;
    rchk(a_st, sx());
    for (int i = 0; i < 3; i++)
    begin
      cwr(8'($random(seed)));
      hrd();
      axw(a_fl, 32'h0);
      flag = 1'h0;
      fchk();
      hwr(8'($random(seed)));
      crd();
    end
    hwr(8'h11);
    hwr(8'hC3);
    axw(a_st, 32'hFF);
    rchk(a_st, sx());
    axw(psp_pkg::ADDR_IRQ_ENABLES, 32'h0);
    en = 1'h0;
    fchk();
    crd();
    hwr(8'h3C);
    mode = 1'h0;
    input_buffer_full = 1'h0;
    axw(a_st, 32'h27);
    rchk(a_st, sx());
    ovf = 1'h0;
    axw(a_st, 32'h07);
    rchk(a_st, sx());
    give_verdict();
  end
  // watchdog
  initial
  begin
    #1000000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
